// >>> hdl/bsp_pkg.sv
// Shared constants and types for the burst-of-two DDR SRAM bus port.
// Assumes the pins are sampled by a system clock much faster than the link clocks.
package bsp_pkg;

  // ****************************************************
  // Organisation
  // ****************************************************
  localparam int BYTE_W = 9;
  localparam int NARROW_DQ_W = 18;
  localparam int WIDE_DQ_W = 36;
  // Address depth of each of the two internal arrays
  localparam int NARROW_ADDR_W = 21;
  localparam int WIDE_ADDR_W = 20;

  // ****************************************************
  // Pipeline and timing
  // ****************************************************
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  // Sampling needs a few system cycles of each link clock phase
  localparam int MIN_HALF_CYC = 3;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic ECHO_RST = 1'b0;
  localparam logic ECHO_N_RST = 1'b1;
  localparam logic OE_RST = 1'b0;

  typedef enum logic [0:0] {
    BSP_LAT_LEGACY = 1'b0,
    BSP_LAT_PLL = 1'b1
  } bsp_lat_t;

  typedef enum logic [0:0] {
    BSP_BEAT_FIRST = 1'b0,
    BSP_BEAT_SECOND = 1'b1
  } bsp_beat_t;

endpackage : bsp_pkg

// >>> hdl/bsp_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output settles once stages two and three agree.
module bsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] filt_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] filt_d;
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("bsp_sync: WIDTH must be at least 1");
    end
  endgenerate

  // Each bit moves only once its last two stages agree
  assign filt_d = (agree & s3_q) | (~agree & filt_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

endmodule : bsp_sync

// >>> hdl/bsp_buf2.sv
// Small valid/ready buffer holding write beats until the array port is free.
// Assumes one clock; out_ready may drop at any cycle to stall draining.
module bsp_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = bsp_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] ent_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] cnt_q;

  generate
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_param
      $error("bsp_buf2: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (PW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = ent_q[rd_ptr_q];

  always_ff @(posedge clk)
  begin
    if (ce && push)
      ent_q[wr_ptr_q] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      wr_ptr_q <= wr_ptr_q + PW'(push);
      rd_ptr_q <= rd_ptr_q + PW'(pop);
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

endmodule : bsp_buf2

// >>> hdl/bsp_port.sv
// Device side of a burst-of-two DDR SRAM bus port with its storage arrays.
// Assumes clk is far faster than the link clocks, which it samples as pins.
//
// Notes on behaviour
// - Write data is captured on the positive and the complementary clock rise.
// - Read data is driven one word per clock rise on both clocks.
// - Data outputs float whenever no read word is being driven.
// - Narrow variant 4M x 18, wide 2M x 36, each as two arrays.
// - A low load strobe at a positive rise latches address and direction.
// - Each loaded access moves exactly two words on consecutive edges.
// - Byte write selects pick stored bytes per beat; others stay unchanged.
// - Select n governs data bits 9n+8 down to 9n.
// - Shared address sampled on the positive rise for reads and writes.
// - Read/write select high means read, low means write, when loaded.
// - Output valid flag follows driven data, aligned with the echo clocks.
// - Accesses start and address and control are captured on the positive clock rise.
// - Complementary rise captures write data and launches read data.
// - Read latency is two and a half cycles, or one with the PLL off.
// - PLL on: first read word after two positive rises at complementary rise, then next.
// - Echo clocks toggle continuously, following the positive input clock.
module bsp_port #(
  parameter int DQ_W = bsp_pkg::NARROW_DQ_W,
  parameter int ADDR_W = bsp_pkg::NARROW_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic k_pin,
  input wire logic k_n_pin,
  input wire logic load_strobe_n,
  input wire logic read_write_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W/bsp_pkg::BYTE_W-1:0] byte_write_select_n,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic pll_disable_n,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  output logic output_valid_flag,
  output logic write_overrun
);

  localparam int BW = bsp_pkg::BYTE_W;
  localparam int LANES = DQ_W / BW;
  localparam int IN_W = 6 + ADDR_W + LANES + DQ_W;
  localparam int ENT_W = 1 + ADDR_W + LANES + DQ_W;
  localparam int MAX_AW = (DQ_W == bsp_pkg::WIDE_DQ_W) ? bsp_pkg::WIDE_ADDR_W
                                                      : bsp_pkg::NARROW_ADDR_W;

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  generate
    if ((DQ_W != bsp_pkg::NARROW_DQ_W && DQ_W != bsp_pkg::WIDE_DQ_W)
        || ADDR_W < 1 || ADDR_W > MAX_AW)
    begin : g_bad_org
      $error("bsp_port: unsupported data width or address depth");
    end
    if (bsp_pkg::LINK_HALF_CYC < bsp_pkg::MIN_HALF_CYC)
    begin : g_bad_rate
      $error("bsp_port: link clock too fast for the sampling clock");
    end
  endgenerate

  // ****************************************************
  // Pin sampling
  // ****************************************************
  logic [IN_W-1:0] pin_q;
  bsp_sync #(.WIDTH(IN_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({pll_disable_n, k_pin, k_n_pin, load_strobe_n, read_write_sel,
               1'b0, addr, byte_write_select_n, dq_in}),
    .filt_q(pin_q)
  );

  wire [DQ_W-1:0] s_dq = pin_q[DQ_W-1:0];
  wire [LANES-1:0] s_wsel_n = pin_q[DQ_W +: LANES];
  wire [ADDR_W-1:0] s_addr = pin_q[DQ_W + LANES +: ADDR_W];
  wire s_rw = pin_q[IN_W-5];
  wire s_load_n = pin_q[IN_W-4];
  wire s_kn = pin_q[IN_W-3];
  wire s_k = pin_q[IN_W-2];
  bsp_pkg::bsp_lat_t lat_mode;
  assign lat_mode = pin_q[IN_W-1] ? bsp_pkg::BSP_LAT_PLL : bsp_pkg::BSP_LAT_LEGACY;
  wire pll_on = (lat_mode == bsp_pkg::BSP_LAT_PLL);

  logic k_prev_q;
  logic kn_prev_q;
  wire k_rise = ce && s_k && !k_prev_q;
  wire kn_rise = ce && s_kn && !kn_prev_q;
  wire edge_any = k_rise || kn_rise;
  wire cmd = k_rise && !s_load_n;
  wire cmd_rd = cmd && s_rw;
  wire cmd_wr = cmd && !s_rw;

  // ****************************************************
  // Read pipeline, advanced on positive rises
  // ****************************************************
  logic st1_v_q, st2_v_q, st3_v_q;
  logic [ADDR_W-1:0] st1_a_q, st2_a_q, st3_a_q;

  // PLL mode: word0 at the complementary rise after two more positive
  // rises, word1 at the following positive rise; legacy is one cycle.
  wire k_lv = pll_on ? st3_v_q : st1_v_q;
  wire [ADDR_W-1:0] k_la = pll_on ? st3_a_q : st1_a_q;
  wire kn_lv = pll_on ? st3_v_q : st2_v_q;
  wire [ADDR_W-1:0] kn_la = pll_on ? st3_a_q : st2_a_q;
  wire launch_v = k_rise ? k_lv : kn_lv;
  wire [ADDR_W-1:0] launch_a = k_rise ? k_la : kn_la;
  wire launch_second = k_rise ? pll_on : !pll_on;
  wire launch_fire = edge_any && launch_v;

  // ****************************************************
  // Storage: two arrays, one per burst word
  // ****************************************************
  logic [DQ_W-1:0] mem0 [2**ADDR_W];
  logic [DQ_W-1:0] mem1 [2**ADDR_W];
  wire [DQ_W-1:0] rd_word = launch_second ? mem1[launch_a] : mem0[launch_a];

  // ****************************************************
  // Write capture
  // ****************************************************
  logic wr0_pend_q, wr1_pend_q;
  logic [ADDR_W-1:0] wr0_a_q, wr1_a_q;

  wire push0 = k_rise && wr0_pend_q;
  wire push1 = kn_rise && wr1_pend_q;
  wire buf_in_valid = push0 || push1;
  wire buf_in_ready;
  wire [ENT_W-1:0] buf_in = push0 ? {bsp_pkg::BSP_BEAT_FIRST, wr0_a_q, s_wsel_n, s_dq}
                                  : {bsp_pkg::BSP_BEAT_SECOND, wr1_a_q, s_wsel_n, s_dq};
  wire buf_out_valid;
  wire [ENT_W-1:0] buf_out;
  // The array port is lent to a read launch first; writes wait in the buffer
  wire drain_fire = buf_out_valid && !launch_fire;

  bsp_buf2 #(.WIDTH(ENT_W), .DEPTH(bsp_pkg::BUF_DEPTH)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(!launch_fire),
    .out_data(buf_out)
  );

  wire [DQ_W-1:0] d_dq = buf_out[DQ_W-1:0];
  wire [LANES-1:0] d_wsel_n = buf_out[DQ_W +: LANES];
  wire [ADDR_W-1:0] d_addr = buf_out[DQ_W + LANES +: ADDR_W];
  wire d_second = buf_out[ENT_W-1];

  always_ff @(posedge clk)
  begin
    if (ce && drain_fire)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!d_wsel_n[i])
        begin
          if (d_second)
            mem1[d_addr][i*BW +: BW] <= d_dq[i*BW +: BW];
          else
            mem0[d_addr][i*BW +: BW] <= d_dq[i*BW +: BW];
        end
      end
    end
  end

  // ****************************************************
  // Sequencing registers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      k_prev_q <= 1'b0;
      kn_prev_q <= 1'b0;
      {st1_v_q, st2_v_q, st3_v_q} <= '0;
      {st1_a_q, st2_a_q, st3_a_q} <= '0;
      {wr0_pend_q, wr1_pend_q} <= '0;
      {wr0_a_q, wr1_a_q} <= '0;
    end
    else if (ce)
    begin
      k_prev_q <= s_k;
      kn_prev_q <= s_kn;
      if (k_rise)
      begin
        st1_v_q <= cmd_rd;
        st1_a_q <= s_addr;
        {st2_v_q, st2_a_q} <= {st1_v_q, st1_a_q};
        {st3_v_q, st3_a_q} <= {st2_v_q, st2_a_q};
        wr0_pend_q <= cmd_wr;
        wr0_a_q <= s_addr;
        wr1_pend_q <= wr0_pend_q;
        wr1_a_q <= wr0_a_q;
      end
      else if (push1)
        wr1_pend_q <= 1'b0;
    end
  end

  // ****************************************************
  // Output registers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out <= '0;
      dq_oe <= bsp_pkg::OE_RST;
      output_valid_flag <= bsp_pkg::OE_RST;
      echo_clock_out <= bsp_pkg::ECHO_RST;
      echo_clock_out_n <= bsp_pkg::ECHO_N_RST;
      write_overrun <= 1'b0;
    end
    else if (ce)
    begin
      if (edge_any)
      begin
        dq_out <= launch_v ? rd_word : '0;
        dq_oe <= launch_v;
        output_valid_flag <= launch_v;
        echo_clock_out <= k_rise;
        echo_clock_out_n <= !k_rise;
      end
      // Sticky: a beat offered to a full buffer would be lost
      if (buf_in_valid && !buf_in_ready)
        write_overrun <= 1'b1;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  logic [ADDR_W-1:0] chk_a_q;
  logic chk_second_q;
  always_ff @(posedge clk)
  begin
    if (ce && drain_fire)
    begin
      chk_a_q <= d_addr;
      chk_second_q <= d_second;
    end
  end
  wire [BW-1:0] lane0_now = d_second ? mem1[d_addr][BW-1:0] : mem0[d_addr][BW-1:0];
  wire [BW-1:0] lane0_chk = chk_second_q ? mem1[chk_a_q][BW-1:0] : mem0[chk_a_q][BW-1:0];

  a_oe_valid_pair: assert property (@(posedge clk) disable iff (!rst_n)
    (dq_oe == output_valid_flag) && (dq_oe || dq_out == '0))
    else $error("output valid flag differs from data drive");

  a_idle_float: assert property (@(posedge clk) disable iff (!rst_n)
    (edge_any && !launch_v) |=> !dq_oe)
    else $error("data bus driven with no read word due");

  a_pll_launch: assert property (@(posedge clk) disable iff (!rst_n)
    (kn_rise && pll_on && st3_v_q) |=> dq_oe && (dq_out == $past(mem0[st3_a_q])))
    else $error("first read word missing at complementary rise");

  a_legacy_launch: assert property (@(posedge clk) disable iff (!rst_n)
    (k_rise && !pll_on && st1_v_q) |=> dq_oe && (dq_out == $past(mem0[st1_a_q])))
    else $error("legacy read word missing one cycle after command");

  a_cmd_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_rd && ce) |=> st1_v_q && (st1_a_q == $past(s_addr)) && !wr0_pend_q)
    else $error("read command not latched with its address");

  a_write_beats: assert property (@(posedge clk) disable iff (!rst_n)
    (k_rise && wr0_pend_q) |-> buf_in_valid ##1 (wr1_pend_q && !push0))
    else $error("write beat not captured");

  a_echo_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (k_rise |=> echo_clock_out && !echo_clock_out_n)
    and (kn_rise |=> !echo_clock_out && echo_clock_out_n))
    else $error("echo clocks do not follow the input clock");

  a_oe_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dq_oe) |-> $past(edge_any))
    else $error("read data launched away from a clock rise");

  a_lane_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && drain_fire && d_wsel_n[0]) |=> (lane0_chk == $past(lane0_now)))
    else $error("deselected byte lane was written");

  // A low enable must hold the data, enable, positive echo and valid outputs where they stand
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable({dq_out, dq_oe, echo_clock_out, output_valid_flag}))
    else $error("outputs moved while the clock enable was low");

  c_pll_read: cover property (@(posedge clk) disable iff (!rst_n)
    kn_rise && pll_on && st3_v_q);
  c_legacy_read: cover property (@(posedge clk) disable iff (!rst_n)
    k_rise && !pll_on && st1_v_q);
  c_write_burst: cover property (@(posedge clk) disable iff (!rst_n) push1);
  c_buffer_full: cover property (@(posedge clk) disable iff (!rst_n)
    buf_out_valid && !buf_in_ready);

endmodule : bsp_port

// >>> verif/bsp_ctrl_model.sv
// Behavioural memory controller on the far side of the SRAM bus port.
// Assumes acc is entered while the positive link clock is low; it returns at a fall.
module bsp_ctrl_model #(
  parameter int ADDR_W = 4,
  parameter int DQ_W = 18
) (
  input wire logic clk,
  output logic k_pin,
  output logic k_n_pin,
  output logic load_strobe_n,
  output logic read_write_sel,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_W/bsp_pkg::BYTE_W-1:0] wsel_n,
  output logic [DQ_W-1:0] dq_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  int k_cnt = 0;

  // ****************************************************
  // Free-running link clocks, phase unrelated to clk
  // ****************************************************
  initial
  begin
    k_pin = 1'b0;
    load_strobe_n = 1'b1;
    read_write_sel = 1'b0;
    addr = '0;
    wsel_n = '1;
    dq_drv = '0;
    #137;
    forever #200 k_pin = ~k_pin;
  end
  assign k_n_pin = ~k_pin;
  always @(posedge k_pin) k_cnt <= k_cnt + 1;

  // ****************************************************
  // One link slot; writes also place both beats
  // ****************************************************
  // Pins move mid-phase so the port's sampled copies never straddle a link edge
  task automatic acc(input logic st, input logic rw, input logic [ADDR_W-1:0] ad,
      input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1,
      input logic [DQ_W/bsp_pkg::BYTE_W-1:0] b0, input logic [DQ_W/bsp_pkg::BYTE_W-1:0] b1,
      output int rno);
    #55;
    @(negedge clk);
    load_strobe_n <= st;
    read_write_sel <= rw;
    addr <= ad;
    dq_drv <= ~dq_drv;
    wsel_n <= '1;
    rno = k_cnt + 1;
    @(posedge k_pin);
    @(negedge k_pin);
    if (!st && !rw)
    begin
      @(negedge clk);
      load_strobe_n <= 1'b1;
      dq_drv <= d0;
      wsel_n <= b0;
      @(posedge k_pin);
      #60;
      @(negedge clk);
      dq_drv <= d1;
      wsel_n <= b1;
      @(negedge k_pin);
    end
  endtask : acc
endmodule : bsp_ctrl_model

// >>> verif/tb_bsp_port.sv
// Self-checking bench for the SRAM bus port driven by a behavioural controller.
// Assumes each echo edge and its read word appear within a link period.
module tb_bsp_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 4;
  localparam int DW = 18;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pll_n = 1'b1;
  logic ce = 1'b1;
  logic last_rd = 1'b0;
  logic k, kn, load_n, rw, echo_q;
  logic dq_oe, echo, echo_n, valid, overrun;
  logic [AW-1:0] a;
  logic [1:0] wsel_n;
  logic [DW-1:0] dq_drv, dq_out;
  logic [DW-1:0] ref0 [16];
  logic [DW-1:0] ref1 [16];
  logic [34:0] exp_q [$];
  logic [15:0] ridx = '0;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h4c43;
  // The port drives the shared data wire only while its enable is high
  wire logic [DW-1:0] dq_bus = dq_oe ? dq_out : dq_drv;

  always #25 clk = ~clk;

  bsp_ctrl_model #(.ADDR_W(AW), .DQ_W(DW)) u_ctrl (.clk(clk), .k_pin(k), .k_n_pin(kn),
    .load_strobe_n(load_n), .read_write_sel(rw), .addr(a), .wsel_n(wsel_n), .dq_drv(dq_drv));

  bsp_port #(.DQ_W(DW), .ADDR_W(AW)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .k_pin(k), .k_n_pin(kn), .load_strobe_n(load_n), .read_write_sel(rw), .addr(a),
    .byte_write_select_n(wsel_n), .dq_in(dq_bus), .pll_disable_n(pll_n), .dq_out(dq_out),
    .dq_oe(dq_oe), .echo_clock_out(echo), .echo_clock_out_n(echo_n),
    .output_valid_flag(valid), .write_overrun(overrun));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check(input logic [34:0] seen, input logic [34:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  function automatic logic [DW-1:0] rnd();
    return DW'($random(seed));
  endfunction : rnd

  task automatic idle(input int n);
    int r;
    repeat (n) u_ctrl.acc(1'b1, 1'(rnd()), AW'(rnd()), rnd(), rnd(), 2'b00, 2'b00, r);
    last_rd = 1'b0;
  endtask : idle

  task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
      input logic [1:0] b0, input logic [1:0] b1);
    int r;
    // Keep write beats clear of the words still coming back from a read;
    // the port's enable lags the link pins by some five clk, past the next K rise
    if (last_rd)
      idle(3);
    u_ctrl.acc(1'b0, 1'b0, ad, d0, d1, b0, b1, r);
    for (int i = 0; i < 2; i++)
    begin
      if (!b0[i]) ref0[ad][9*i+:9] = d0[9*i+:9];
      if (!b1[i]) ref1[ad][9*i+:9] = d1[9*i+:9];
    end
  endtask : wr

  task automatic rd(input logic [AW-1:0] ad);
    int r;
    u_ctrl.acc(1'b0, 1'b1, ad, '0, '0, 2'b11, 2'b11, r);
    last_rd = 1'b1;
    if (pll_n)
    begin
      exp_q.push_back({16'(r + 2), 1'b0, ref0[ad]});
      exp_q.push_back({16'(r + 3), 1'b1, ref1[ad]});
    end
    else
    begin
      exp_q.push_back({16'(r + 1), 1'b1, ref0[ad]});
      exp_q.push_back({16'(r + 1), 1'b0, ref1[ad]});
    end
  endtask : rd

  task automatic mixed(input int n);
    repeat (n)
    begin
      if ($random(seed) & 1)
        rd(AW'(rnd()));
      else
        wr(AW'(rnd()), rnd(), rnd(), 2'(rnd()), 2'(rnd()));
    end
  endtask : mixed

  task automatic set_mode(input logic m);
    idle(4);
    @(negedge clk);
    pll_n = m;
    // One frozen cycle in a quiet slot; a link half period still sees enough samples
    ce = 1'b0;
    @(negedge clk);
    ce = 1'b1;
    @(negedge k);
  endtask : set_mode

  // ****************************************************
  // Output monitor
  // ****************************************************
  always @(negedge clk)
  begin
    if (rst_n)
    begin
      check(35'({dq_oe, echo_n, overrun}), 35'({valid, ~echo, 1'b0}), "flags");
      if (echo && !echo_q)
      begin
        if (ridx != 0) check(35'(u_ctrl.k_cnt), 35'(ridx + 16'h1), "echo");
        ridx = 16'(u_ctrl.k_cnt);
      end
      if (echo !== echo_q && valid === 1'b1)
      begin
        if (exp_q.size() == 0) check(35'h1, 35'h0, "extra word");
        else check({ridx, echo, dq_out}, exp_q.pop_front(), "word");
      end
    end
    echo_q = echo;
  end

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial
  begin
    repeat (10) @(negedge clk);
    check(35'({dq_oe, valid, echo, echo_n, overrun, dq_out}), 35'h80000, "reset");
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    @(negedge k);
    for (int i = 0; i < 16; i++) wr(i[3:0], rnd(), rnd(), 2'b00, 2'b00);
    for (int i = 0; i < 16; i++) rd(i[3:0]);
    for (int i = 0; i < 4; i++)
    begin
      wr(i[3:0], rnd(), rnd(), i[1:0], ~i[1:0]);
      rd(i[3:0]);
    end
    idle(4);
    mixed(24);
    set_mode(1'b0);
    mixed(24);
    set_mode(1'b1);
    mixed(8);
    idle(6);
    check(35'(exp_q.size()), 35'h0, "words left");
    conclude();
  end

  initial
  begin
    #1000000;
    errors++;
    conclude();
  end
endmodule : tb_bsp_port
